// ### src/hipd_pkg.sv
package hipd_pkg;
  // detector variants selectable at elaboration
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_COUNT = 2'h1;
  // shift-register depth and counter terminal count
  localparam int SHIFT_DEPTH = 8;
  localparam int COUNT_TERMINAL = 16;
  // longest legitimate gap between strobes, in host input clocks
  localparam int STROBE_GAP_MAX = 10;
  localparam int COUNT_WIDTH = 5;
  localparam logic [4:0] COUNT_ZERO = 5'h00;
  localparam logic [4:0] COUNT_ONE = 5'h01;
  // reference clock rate, used only for documentation of timing
  localparam int REF_CLK_MHZ = 40;
  localparam int REF_CLK_PERIOD_NS = 25;
endpackage

// ### src/hipd_counter.sv
module hipd_counter #(
  parameter int TERMINAL = hipd_pkg::COUNT_TERMINAL,
  parameter int WIDTH = hipd_pkg::COUNT_WIDTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_load_zero,
  output logic o_terminal,
  output logic [WIDTH-1:0] o_count
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic terminal;
  logic next_terminal;
  localparam logic [WIDTH-1:0] TERM_VAL = WIDTH'(TERMINAL);
  localparam logic [WIDTH-1:0] ONE_VAL = WIDTH'(1);

  always_comb begin
    next_count = count;
    next_terminal = terminal;
    if (i_load_zero) begin
      next_count = '0;
      next_terminal = 1'b0;
    end else if (!terminal) begin
      // terminal flag doubles as the count enable, so it parks at terminal
      next_count = count + ONE_VAL;
      next_terminal = (next_count == TERM_VAL);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
      terminal <= 1'b0;
    end else begin
      count <= next_count;
      terminal <= next_terminal;
    end
  end

  assign o_terminal = terminal;
  assign o_count = count;
endmodule

// ### src/hipd_detector.sv
// Contract
// - While the phase clock stays static the shift detector shifts a one in on every input clock.
// - After eight shifts with no activity the standby select output goes high.
// - Each low-to-high phase clock transition clears the shift detector, expected at least every two clocks.
// - The strobe counter must reach at least eleven since ten clocks may legitimately pass without a strobe.
// - The strobe counter counts sixteen clocks before its terminal flag drives standby select high.
// - A low strobe loads zero into the counter and clears the terminal flag.
// - The terminal flag is the counter's enable so it holds at sixteen.
// - For hosts that park the strobe low the strobe is inverted before use.
// - In combined mode the strobe is XNORed with a port bit, low bit detecting a static low strobe.
// - Standby select is active high: high means standby, low means active.
module hipd_detector #(
  parameter logic [1:0] MODE = hipd_pkg::MODE_SHIFT,
  parameter int SHIFT_DEPTH = hipd_pkg::SHIFT_DEPTH,
  parameter int COUNT_TERMINAL = hipd_pkg::COUNT_TERMINAL
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_phase_clk,
  input wire logic i_latch_strobe,
  input wire logic i_invert_strobe,
  input wire logic i_combined_en,
  input wire logic i_port_bit,
  output logic o_standby_sel_n,
  output logic [hipd_pkg::COUNT_WIDTH-1:0] o_idle_count
);
  typedef enum logic [1:0] {
    HIPD_ACTIVE = 2'b01,
    HIPD_STANDBY = 2'b10
  } hipd_state_t;

  hipd_state_t state;
  hipd_state_t next_state;
  logic [SHIFT_DEPTH-1:0] shreg;
  logic [SHIFT_DEPTH-1:0] next_shreg;
  logic phase_prev;
  logic next_phase_prev;
  logic strobe_eff;
  logic cnt_load;
  logic cnt_term;
  logic idle;
  logic standby;
  logic next_standby;
  logic [hipd_pkg::COUNT_WIDTH-1:0] cnt_val;

  // conditioned strobe: high means bus is quiet in the chosen sense
  function automatic logic cond_strobe(input logic s, input logic inv, input logic comb, input logic pb);
    logic r;
    r = inv ? ~s : s;
    if (comb) begin
      r = ~(s ^ pb);
    end
    return r;
  endfunction

  // the port bit is sampled as-is; it must stay put while the host sleeps
  assign strobe_eff = cond_strobe(i_latch_strobe, i_invert_strobe, i_combined_en, i_port_bit);

  // conditioned level low acts as the load, like a held-high strobe idles
  assign cnt_load = ~strobe_eff;

  hipd_counter #(
    .TERMINAL(COUNT_TERMINAL),
    .WIDTH(hipd_pkg::COUNT_WIDTH)
  ) u_counter (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_load_zero(cnt_load),
    .o_terminal(cnt_term),
    .o_count(cnt_val)
  );

  always_comb begin
    next_phase_prev = i_phase_clk;
    next_shreg = {shreg[SHIFT_DEPTH-2:0], 1'b1};
    if (i_phase_clk && !phase_prev) begin
      // rising phase edge is the clear; a slower edge would be a host fault
      next_shreg = '0;
    end
  end

  // terminal of 16 exceeds the worst legal gap of 10 with margin
  assign idle = (MODE == hipd_pkg::MODE_SHIFT) ? shreg[SHIFT_DEPTH-1] : cnt_term;

  always_comb begin
    next_state = state;
    case (state)
      HIPD_ACTIVE: begin
        if (idle) begin
          next_state = HIPD_STANDBY;
        end
      end
      HIPD_STANDBY: begin
        // host wakes with dummy strobes, so leaving here early is safe
        if (!idle) begin
          next_state = HIPD_ACTIVE;
        end
      end
      default: begin
        next_state = HIPD_ACTIVE;
      end
    endcase
    next_standby = (next_state == HIPD_STANDBY);
  end

  // shift group only registers what its own always_comb worked out
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shreg <= '0;
      phase_prev <= 1'b0;
    end else begin
      shreg <= next_shreg;
      phase_prev <= next_phase_prev;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= HIPD_ACTIVE;
      standby <= 1'b0;
    end else begin
      state <= next_state;
      standby <= next_standby;
    end
  end

  assign o_standby_sel_n = standby;
  assign o_idle_count = cnt_val;
endmodule

// ### sim/hipd_host.sv
module hipd_host (
  input wire logic i_clk,
  input wire logic i_idle,
  input wire logic i_park,
  input wire logic [3:0] i_gap,
  output logic o_strobe,
  output logic o_phase
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] n = 4'h0;
  initial o_strobe = 1'b1;
  initial o_phase = 1'b0;
  // phase toggling resumes at once on wake; the first strobe pulse follows i_gap clocks later, ahead of any fetch
  always @(posedge i_clk) begin
    n <= i_idle || n >= i_gap ? 4'h0 : n + 4'h1;
    o_strobe <= i_idle || n < i_gap ? i_park : ~i_park;
    // toggling gives a rise every second clock; idle parks it static
    o_phase <= i_idle ? i_park : ~o_phase;
  end
endmodule

// ### sim/hipd_detector_properties.sv
module hipd_props #(
  parameter logic [1:0] MODE = hipd_pkg::MODE_COUNT
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_phase_clk,
  input wire logic i_latch_strobe,
  input wire logic i_invert_strobe,
  input wire logic i_combined_en,
  input wire logic i_port_bit,
  input wire logic o_standby_sel_n,
  input wire logic [4:0] o_idle_count
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // the counter runs in both variants, but only one of them drives standby
  localparam bit IS_COUNT = (MODE == hipd_pkg::MODE_COUNT);
  localparam bit IS_SHIFT = (MODE == hipd_pkg::MODE_SHIFT);
  wire s = i_combined_en ? ~(i_latch_strobe ^ i_port_bit) : i_latch_strobe ^ i_invert_strobe;
  AST_LOAD: assert property (!s |=> o_idle_count == 5'h00) else $error("no load");
  AST_UP: assert property (s && o_idle_count < 5'h10 |=> o_idle_count == $past(o_idle_count) + 5'h01)
    else $error("no step");
  AST_HOLD: assert property (s && o_idle_count == 5'h10 |=> $stable(o_idle_count)) else $error("no hold");
  AST_MAX: assert property (o_idle_count <= 5'h10) else $error("overrun");
  AST_SET: assert property (IS_COUNT && o_idle_count == 5'h10 |=> o_standby_sel_n) else $error("no standby");
  AST_CLR: assert property (IS_COUNT && o_idle_count < 5'h10 |=> !o_standby_sel_n) else $error("bad standby");
  AST_GAP: assert property (IS_COUNT && $rose(o_standby_sel_n) |-> $past(s, 16)) else $error("early");
  // right after reset the design may see a rise that the past value hides
  AST_SH_SET: assert property ((IS_SHIFT && (!i_phase_clk || $past(i_phase_clk) && $past(i_rst_n))) [*8]
    |=> ##1 o_standby_sel_n) else $error("no shift standby");
  AST_SH_CLR: assert property (IS_SHIFT && i_phase_clk && !$past(i_phase_clk) |-> ##2 !o_standby_sel_n)
    else $error("no shift wake");
  AST_RST: assert property (disable iff (1'b0) !i_rst_n [*2] |-> !o_standby_sel_n && o_idle_count == 5'h00)
    else $error("reset");
  cover property (i_combined_en && o_idle_count == 5'h10);
  cover property (i_invert_strobe && o_standby_sel_n);
  cover property ($fell(o_standby_sel_n));
  cover property (IS_SHIFT && $rose(o_standby_sel_n));
endmodule
bind hipd_detector hipd_props #(.MODE(MODE)) props (.*);

// ### sim/test_host_idle_powerdown_detector.sv
module test_host_idle_powerdown_detector;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, idle = 1'b0, park = 1'b1, inv = 1'b0, comb = 1'b0, pbit = 1'b0, strb, sel_n;
  logic [3:0] gap = 4'h9;
  logic [4:0] cnt;
  logic [31:0] rs = 32'h0000_0017;
  int num_errors = 0, total_checks = 0;
  logic phs, sel_sh;
  hipd_host host (.i_clk(clk), .i_idle(idle), .i_park(park), .i_gap(gap), .o_strobe(strb), .o_phase(phs));
  hipd_detector #(.MODE(hipd_pkg::MODE_COUNT)) dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_phase_clk(phs),
    .i_latch_strobe(strb), .i_invert_strobe(inv), .i_combined_en(comb), .i_port_bit(pbit),
    .o_standby_sel_n(sel_n), .o_idle_count(cnt));
  // second variant sees the same host, so both detectors are judged on one run
  hipd_detector #(.MODE(hipd_pkg::MODE_SHIFT)) dut_shift (.i_ref_clk(clk), .i_rst_n(rst_n), .i_phase_clk(phs),
    .i_latch_strobe(strb), .i_invert_strobe(inv), .i_combined_en(comb), .i_port_bit(pbit),
    .o_standby_sel_n(sel_sh), .o_idle_count());
  initial forever #12.5 clk = ~clk;
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // strobe level that each mode reads as idle
  function logic idle_lvl(input logic [1:0] md);
    return md == 2'h1 ? 1'b0 : (md[1] ? md[0] : 1'b1);
  endfunction
  task chk(input logic [4:0] got, input logic [4:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    #50000;
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      idle <= 1'b0;
      // port bit only moves once the host is awake again
      @(posedge clk);
      rs = xs(rs);
      inv <= k % 4 == 1;
      comb <= k[1];
      pbit <= k[0];
      park <= idle_lvl(k[1:0]);
      // first pass keeps the longest legal gap
      gap <= k == 0 ? 4'ha : rs[3:0] % 4'ha;
      wt(13);
      chk({4'h0, sel_n}, 5'h00);
      chk({4'h0, sel_sh}, 5'h00);
      @(posedge clk);
      idle <= 1'b1;
      wt(24);
      chk(cnt, 5'h10);
      chk({4'h0, sel_n}, 5'h01);
      chk({4'h0, sel_sh}, 5'h01);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    wt(2);
    chk(cnt, 5'h00);
    chk({4'h0, sel_n}, 5'h00);
    chk({4'h0, sel_sh}, 5'h00);
    give_verdict;
  end
endmodule
